// ---- rtl/fcsu_pkg.sv ----
// package for the flash crc/checksum signature unit
// assumes a wishbone classic slave with 32-bit data, one register per word
package fcsu_pkg;
   // ==========================================================
   // register byte offsets
   localparam logic [5:0] FCSU_OFS_START_HIGH  = 6'h00;
   localparam logic [5:0] FCSU_OFS_END_HIGH    = 6'h04;
   localparam logic [5:0] FCSU_OFS_START_MID   = 6'h08;
   localparam logic [5:0] FCSU_OFS_END_MID     = 6'h0C;
   localparam logic [5:0] FCSU_OFS_START_LOW   = 6'h10;
   localparam logic [5:0] FCSU_OFS_END_LOW     = 6'h14;
   localparam logic [5:0] FCSU_OFS_CONTROL     = 6'h18;
   localparam logic [5:0] FCSU_OFS_RESULT_HIGH = 6'h1C;
   localparam logic [5:0] FCSU_OFS_RESULT_LOW  = 6'h20;
   localparam logic [5:0] FCSU_OFS_DATA_IN     = 6'h24;
   // ==========================================================
   // control register fields
   localparam int FCSU_BIT_RUN   = 0;
   localparam int FCSU_BIT_CLK_LO = 1;
   localparam int FCSU_BIT_CLK_HI = 3;
   localparam int FCSU_BIT_ALG   = 5;
   localparam int FCSU_BIT_CLEAR = 6;
   localparam int FCSU_BIT_MODE  = 7;
   // ==========================================================
   // reset values and constants
   localparam logic [7:0]  FCSU_RST_END_LOW  = 8'h0F;
   localparam logic [3:0]  FCSU_LOW_START_FILL = 4'h0;
   localparam logic [3:0]  FCSU_LOW_END_FILL   = 4'hF;
   localparam logic [15:0] FCSU_POLY       = 16'h8C81;
   localparam logic [15:0] FCSU_CRC_INIT   = 16'hFFFF;
   localparam logic [15:0] FCSU_SUM_INIT   = 16'h0000;
   localparam logic [2:0]  FCSU_CLK_DIV1   = 3'h0;
   localparam logic [2:0]  FCSU_CLK_DIV2   = 3'h1;
   localparam logic [2:0]  FCSU_CLK_DIV4   = 3'h2;
   localparam logic [2:0]  FCSU_CLK_DIV8   = 3'h3;
   localparam logic [2:0]  FCSU_CLK_SYS    = 3'h4;
   localparam int          FCSU_ADDR_W     = 17;
   typedef enum logic [1:0] {
      FCSU_IDLE  = 2'b00,
      FCSU_READ  = 2'b01,
      FCSU_WAIT  = 2'b10
   } fcsu_state_t;
endpackage

// ---- rtl/fcsu_engine.sv ----
// one-byte signature step: crc-16 msb first or 16-bit additive checksum
// assumes byte presented with a one-cycle strobe on the system clock
`timescale 1ns/1ps
module fcsu_engine
   import fcsu_pkg::*;
(
   input  wire logic        sys_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        load_in,
   input  wire logic        algorithm_select_in,
   input  wire logic        step_in,
   input  wire logic [7:0]  byte_in,
   output logic      [15:0] sig_out
);
   // ==========================================================
   // combinational step
   logic [15:0] crc_chain [0:8];
   logic [15:0] crc_next;
   logic [15:0] sum_next;
   logic [15:0] next_sig;
   assign crc_chain[0] = sig_out;
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_bit
         wire fb = crc_chain[g][15] ^ byte_in[7 - g];
         assign crc_chain[g + 1] = {crc_chain[g][14:0], 1'b0} ^ (fb ? FCSU_POLY : 16'h0000);
      end
   endgenerate
   assign crc_next = crc_chain[8];
   assign sum_next = sig_out + {8'h00, byte_in};
   assign next_sig = load_in ? (algorithm_select_in ? FCSU_SUM_INIT : FCSU_CRC_INIT) :
                     (algorithm_select_in ? sum_next : crc_next);
   // ==========================================================
   // signature register
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sig_out <= FCSU_CRC_INIT;
      end else if (load_in || step_in) begin
         sig_out <= next_sig;
      end
   end
endmodule // fcsu_engine

// ---- rtl/fcsu_top.sv ----
// flash crc/checksum signature unit: wishbone registers, flash reader, cpu stall
// assumes a one-cycle-latency synchronous flash read port and an rc clock tick input
//
// Summary of operation
// - compute a 16-bit signature over flash bytes for software comparison
// - crc polynomial x16+x15+x11+x10+x7+1, constant 8C81
// - calculation rate from rc clock /1,/2,/4,/8 or system clock
// - auto mode reads flash itself; user mode takes bytes from software
// - software sets mode, algorithm, clock, addresses, then start; range processed
// - during auto run the cpu is stalled and interrupts masked
// - user mode: each data-in write updates signature, readable as two bytes
// - checksum alternative in both modes sharing the same registers
// - start bit begins run, reads one while busy, zero write aborts
// - clear bit self-clears; in user mode it loads ffff for crc, 0000 for checksum
// - mode bit 0 auto, 1 user; algorithm bit 0 crc, 1 checksum
// - clock codes 000..011 rc divided 1,2,4,8; 100 system clock
//
// The Wishbone register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module fcsu_top
   import fcsu_pkg::*;
#(
   parameter int ADDR_W = FCSU_ADDR_W
)(
   input  wire logic              sys_clk_in,
   input  wire logic              rst_n_in,
   input  wire logic              wb_cyc_in,
   input  wire logic              wb_stb_in,
   input  wire logic              wb_we_in,
   input  wire logic [5:0]        wb_adr_in,
   input  wire logic [3:0]        wb_sel_in,
   input  wire logic [31:0]       wb_dat_in,
   output logic      [31:0]       wb_dat_out,
   output logic                   wb_ack_out,
   output logic                   wb_err_out,
   input  wire logic              rc_tick_in,
   output logic      [ADDR_W-1:0] flash_addr_out,
   output logic                   flash_rd_out,
   input  wire logic [7:0]        flash_data_in,
   output logic                   cpu_stall_out,
   output logic                   irq_mask_out
);
   // ==========================================================
   // elaboration check
   // range registers hold exactly this many address bits; refuse any other width
   generate
      if (ADDR_W != FCSU_ADDR_W) begin : g_bad_width
         $error("fcsu_top: ADDR_W must match the range register width");
      end
   endgenerate

   // ==========================================================
   // registers
   logic [7:0]  range_start_high;
   logic [7:0]  range_start_middle;
   logic [3:0]  range_start_low;
   logic [7:0]  range_end_high;
   logic [7:0]  range_end_middle;
   logic [3:0]  range_end_low;
   logic        feed_mode_select;
   logic        algorithm_select;
   logic [2:0]  calc_clock_select;
   logic        calc_start_busy;
   logic [15:0] sig;
   fcsu_state_t state;
   logic [ADDR_W-1:0] cur_addr;
   logic [2:0]  div_cnt;
   logic        rc_s1;
   logic        rc_s2;
   logic        rc_s3;

   // ==========================================================
   // bus decode
   wire bus_req      = wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_err_out;
   wire hit_sh       = wb_adr_in == FCSU_OFS_START_HIGH;
   wire hit_eh       = wb_adr_in == FCSU_OFS_END_HIGH;
   wire hit_sm       = wb_adr_in == FCSU_OFS_START_MID;
   wire hit_em       = wb_adr_in == FCSU_OFS_END_MID;
   wire hit_sl       = wb_adr_in == FCSU_OFS_START_LOW;
   wire hit_el       = wb_adr_in == FCSU_OFS_END_LOW;
   wire hit_ctl      = wb_adr_in == FCSU_OFS_CONTROL;
   wire hit_rh       = wb_adr_in == FCSU_OFS_RESULT_HIGH;
   wire hit_rl       = wb_adr_in == FCSU_OFS_RESULT_LOW;
   wire hit_din      = wb_adr_in == FCSU_OFS_DATA_IN;
   wire hit_any      = hit_sh | hit_eh | hit_sm | hit_em | hit_sl | hit_el | hit_ctl | hit_rh | hit_rl | hit_din;
   wire wr_lane0     = bus_req && wb_we_in && wb_sel_in[0];
   wire wr_ctl       = wr_lane0 && hit_ctl;
   wire wr_din       = wr_lane0 && hit_din;
   wire [7:0] wbyte  = wb_dat_in[7:0];
   wire [7:0] ctl_rd = {feed_mode_select, 1'b0, algorithm_select, 1'b0, calc_clock_select, calc_start_busy};
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      if (hit_sh) rd_mux = range_start_high;
      if (hit_eh) rd_mux = range_end_high;
      if (hit_sm) rd_mux = range_start_middle;
      if (hit_em) rd_mux = range_end_middle;
      if (hit_sl) rd_mux = {range_start_low, FCSU_LOW_START_FILL};
      if (hit_el) rd_mux = {range_end_low, FCSU_LOW_END_FILL};
      if (hit_ctl) rd_mux = ctl_rd;
      if (hit_rh) rd_mux = sig[15:8];
      if (hit_rl) rd_mux = sig[7:0];
   end

   // ==========================================================
   // bus answer: one cycle after the request
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wb_ack_out <= 1'b0;
         wb_err_out <= 1'b0;
         wb_dat_out <= 32'h0000_0000;
      end else begin
         wb_ack_out <= bus_req && hit_any;
         wb_err_out <= bus_req && !hit_any;
         wb_dat_out <= {24'h00_0000, rd_mux};
      end
   end

   // ==========================================================
   // configuration registers; the cpu is stalled during a run so
   // address writes then only come from a misbehaving master
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         range_start_high   <= 8'h00;
         range_start_middle <= 8'h00;
         range_start_low    <= 4'h0;
         range_end_high     <= 8'h00;
         range_end_middle   <= 8'h00;
         range_end_low      <= FCSU_RST_END_LOW[7:4];
         feed_mode_select   <= 1'b0;
         algorithm_select   <= 1'b0;
         calc_clock_select  <= FCSU_CLK_DIV1;
      end else if (wr_lane0) begin
         if (hit_sh) range_start_high <= {7'h00, wbyte[0]};
         if (hit_eh) range_end_high <= {7'h00, wbyte[0]};
         if (hit_sm) range_start_middle <= wbyte;
         if (hit_em) range_end_middle <= wbyte;
         if (hit_sl) range_start_low <= wbyte[7:4];
         if (hit_el) range_end_low <= wbyte[7:4];
         if (hit_ctl) begin
            feed_mode_select  <= wbyte[FCSU_BIT_MODE];
            algorithm_select  <= wbyte[FCSU_BIT_ALG];
            calc_clock_select <= wbyte[FCSU_BIT_CLK_HI:FCSU_BIT_CLK_LO];
         end
      end
   end

   // ==========================================================
   // calculation rate
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rc_s1 <= 1'b0;
         rc_s2 <= 1'b0;
         rc_s3 <= 1'b0;
      end else begin
         rc_s1 <= rc_tick_in;
         rc_s2 <= rc_s1;
         rc_s3 <= rc_s2;
      end
   end
   // rc clock arrives as a level toggling each rc cycle; one edge per rc period
   wire rc_edge = rc_s2 && !rc_s3;
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div_cnt <= 3'h0;
      end else if (rc_edge) begin
         div_cnt <= div_cnt + 3'h1;
      end
   end
   logic calc_tick;
   always_comb begin
      unique case (calc_clock_select)
         FCSU_CLK_DIV1: calc_tick = rc_edge;
         FCSU_CLK_DIV2: calc_tick = rc_edge && (div_cnt[0] == 1'b1);
         FCSU_CLK_DIV4: calc_tick = rc_edge && (div_cnt[1:0] == 2'h3);
         FCSU_CLK_DIV8: calc_tick = rc_edge && (div_cnt == 3'h7);
         FCSU_CLK_SYS:  calc_tick = 1'b1;
         default:       calc_tick = 1'b0;
      endcase
   end

   // ==========================================================
   // auto run sequencer
   wire [ADDR_W-1:0] start_addr = {range_start_high[0], range_start_middle, range_start_low, FCSU_LOW_START_FILL};
   wire [ADDR_W-1:0] end_addr   = {range_end_high[0], range_end_middle, range_end_low, FCSU_LOW_END_FILL};
   wire start_req = wr_ctl && wbyte[FCSU_BIT_RUN] && !feed_mode_select && !wbyte[FCSU_BIT_MODE];
   wire abort_req = wr_ctl && !wbyte[FCSU_BIT_RUN] && calc_start_busy;
   wire last_byte = cur_addr == end_addr;
   wire auto_step = state == FCSU_WAIT;
   wire run_done  = auto_step && (last_byte || (cur_addr > end_addr));
   logic [7:0] step_byte;
   assign step_byte = auto_step ? flash_data_in : wbyte;
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state           <= FCSU_IDLE;
         cur_addr        <= '0;
         calc_start_busy <= 1'b0;
      end else begin
         unique case (state)
            FCSU_IDLE: begin
               if (start_req) begin
                  state           <= FCSU_READ;
                  cur_addr        <= start_addr;
                  calc_start_busy <= 1'b1;
               end
            end
            FCSU_READ: begin
               if (abort_req) begin
                  state           <= FCSU_IDLE;
                  calc_start_busy <= 1'b0;
               end else if (calc_tick) begin
                  state <= FCSU_WAIT;
               end
            end
            FCSU_WAIT: begin
               if (run_done || abort_req) begin
                  state           <= FCSU_IDLE;
                  calc_start_busy <= 1'b0;
               end else begin
                  state    <= FCSU_READ;
                  cur_addr <= cur_addr + 1'b1;
               end
            end
            default: begin
               state           <= FCSU_IDLE;
               calc_start_busy <= 1'b0;
            end
         endcase
      end
   end
   assign flash_rd_out   = (state == FCSU_READ) && calc_tick;
   assign flash_addr_out = cur_addr;
   assign cpu_stall_out  = calc_start_busy;
   assign irq_mask_out   = calc_start_busy;

   // ==========================================================
   // signature engine; clear only in user mode, per the clear bit
   wire clear_req = wr_ctl && wbyte[FCSU_BIT_CLEAR] && wbyte[FCSU_BIT_MODE];
   wire user_step = wr_din && feed_mode_select && !calc_start_busy;
   fcsu_engine u_engine (
      .sys_clk_in          (sys_clk_in),
      .rst_n_in            (rst_n_in),
      .load_in             (clear_req),
      .algorithm_select_in (wr_ctl ? wbyte[FCSU_BIT_ALG] : algorithm_select),
      .step_in             ((auto_step && !abort_req) || user_step),
      .byte_in             (step_byte),
      .sig_out             (sig)
   );

   // ==========================================================
   // checks
   // stall and mask are checked against the sequencer state, not the busy flag they copy
   a_busy_stall: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      cpu_stall_out == (state != FCSU_IDLE) && irq_mask_out == (state != FCSU_IDLE))
      else $error("stall or mask does not follow the run");
   a_start_sets_busy: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (start_req && state == FCSU_IDLE) |=> calc_start_busy && cur_addr == $past(start_addr))
      else $error("start did not set busy at start address");
   a_abort_clears: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      abort_req |=> !calc_start_busy)
      else $error("abort left the run busy");
   a_addr_ascends: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (auto_step && !run_done && !abort_req) |=> cur_addr == $past(cur_addr) + 1'b1)
      else $error("address did not ascend by one");
   a_end_included: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (auto_step && last_byte) |=> !calc_start_busy && state == FCSU_IDLE)
      else $error("run did not stop at end address");
   a_clear_crc: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (clear_req && !wbyte[FCSU_BIT_ALG]) |=> sig == FCSU_CRC_INIT)
      else $error("clear did not load all ones");
   a_clear_sum: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (clear_req && wbyte[FCSU_BIT_ALG]) |=> sig == FCSU_SUM_INIT)
      else $error("clear did not load zero");
   a_sum_adds: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (user_step && algorithm_select && !clear_req) |=> sig == $past(sig) + {8'h00, $past(wbyte)})
      else $error("checksum did not add the byte");
   a_sys_rate: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (state == FCSU_READ && calc_clock_select == FCSU_CLK_SYS && !abort_req) |-> flash_rd_out)
      else $error("system clock rate stalled read");
   a_rc_rate: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (flash_rd_out && calc_clock_select != FCSU_CLK_SYS) |-> rc_edge)
      else $error("rc rate read without an rc edge");
   a_rd_pulse: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      flash_rd_out |=> !flash_rd_out)
      else $error("flash read strobe longer than one cycle");
   a_din_ignored: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (wr_din && !feed_mode_select && state == FCSU_IDLE) |=> sig == $past(sig))
      else $error("data-in write changed the result in auto mode");
   a_ack_one: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      wb_ack_out |=> !wb_ack_out)
      else $error("ack held longer than one cycle");
   // covers: one per main scenario
   c_auto_run: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) run_done);
   c_abort: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) abort_req);
   c_user_feed: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) user_step);
   c_unmapped: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) wb_err_out);
   c_rc_slow: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      flash_rd_out && calc_clock_select == FCSU_CLK_DIV8);
endmodule // fcsu_top

// ---- testbench/fcsu_flash_model.sv ----
// program flash read port model for the signature unit bench
// assumes one-cycle read latency; data is a fixed function of the address
`timescale 1ns/1ps
module fcsu_flash_model
   import fcsu_pkg::*;
#(
   parameter int ADDR_W = FCSU_ADDR_W
)(
   input  wire logic              sys_clk_in,
   input  wire logic              rst_n_in,
   input  wire logic [ADDR_W-1:0] flash_addr_in,
   input  wire logic              flash_rd_in,
   output logic      [7:0]        flash_data_out
);
   // ==========================================================
   // read port
   // outside the valid cycle the data inverts, so a stale sample shows
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flash_data_out <= 8'hC3;
      end else if (flash_rd_in) begin
         flash_data_out <= flash_addr_in[7:0] ^ 8'h5A ^ {flash_addr_in[10:8], 5'h00};
      end else begin
         flash_data_out <= ~flash_data_out;
      end
   end
endmodule // fcsu_flash_model

// ---- testbench/flash_crc_checksum_unit_bench.sv ----
// self-checking bench for the flash signature unit
// assumes the flash model answers one cycle after each read strobe
`timescale 1ns/1ps
module flash_crc_checksum_unit_bench;
   import fcsu_pkg::*;
   // ==========================================================
   // signals
   localparam int AW = FCSU_ADDR_W;
   logic          sys_clk     = 1'b0;
   logic          rc_clk      = 1'b0;
   logic          rst_n       = 1'b0;
   logic          cyc         = 1'b0;
   logic          stb         = 1'b0;
   logic          we          = 1'b0;
   logic [5:0]    adr         = 6'h00;
   logic [31:0]   dat_w       = 32'h0000_0000;
   logic [31:0]   dat_r;
   logic          ack;
   logic          err;
   logic [AW-1:0] f_addr;
   logic          f_rd;
   logic [7:0]    f_data;
   logic          stall;
   logic          mask;
   int            err_total   = 0;
   int            comparisons = 0;
   logic [7:0]    q;
   logic          e;
   logic [15:0]   res;
   logic [15:0]   exp;
   logic [5:0]    ofs [10] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h1C, 6'h20, 6'h24};
   logic [7:0]    rst_v [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0F, 8'h00, 8'hFF, 8'hFF, 8'h00};

   always #2 sys_clk = ~sys_clk;
   // rc oscillator unrelated in phase to the system clock
   initial begin
      #3;
      forever #10 rc_clk = ~rc_clk;
   end

   fcsu_top #(.ADDR_W(AW)) DUT (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(dat_w), .wb_dat_out(dat_r),
      .wb_ack_out(ack), .wb_err_out(err), .rc_tick_in(rc_clk), .flash_addr_out(f_addr),
      .flash_rd_out(f_rd), .flash_data_in(f_data), .cpu_stall_out(stall), .irq_mask_out(mask));
   fcsu_flash_model #(.ADDR_W(AW)) flash (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .flash_addr_in(f_addr),
      .flash_rd_in(f_rd), .flash_data_out(f_data));

   // ==========================================================
   // reference and bus tasks
   function automatic logic [15:0] step(input logic [15:0] s, input logic [7:0] b, input logic alg);
      logic fb;
      if (alg) return s + {8'h00, b};
      for (int i = 7; i >= 0; i--) begin
         fb = s[15] ^ b[i];
         s  = {s[14:0], 1'b0} ^ (fb ? FCSU_POLY : 16'h0000);
      end
      return s;
   endfunction

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] want);
      comparisons++;
      if (seen !== want) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", name, want, seen);
      end
   endtask

   // holds the request until ack or err is sampled high at an edge
   task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
      int n;
      @(posedge sys_clk);
      cyc   <= 1'b1;
      stb   <= 1'b1;
      we    <= w;
      adr   <= a;
      dat_w <= {24'h00_0000, d};
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
      q = dat_r[7:0];
      e = err;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 50) begin
         err_total++;
         stop_test();
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      xfer(1'b1, a, d);
   endtask

   task automatic get_result();
      xfer(1'b0, FCSU_OFS_RESULT_HIGH, 8'h00);
      res[15:8] = q;
      xfer(1'b0, FCSU_OFS_RESULT_LOW, 8'h00);
      res[7:0] = q;
   endtask

   task automatic set_range(input logic [AW-1:0] a0, input logic [AW-1:0] a1);
      wr(FCSU_OFS_START_HIGH, {7'h00, a0[16]});
      wr(FCSU_OFS_START_MID, a0[15:8]);
      wr(FCSU_OFS_START_LOW, a0[7:0]);
      wr(FCSU_OFS_END_HIGH, {7'h00, a1[16]});
      wr(FCSU_OFS_END_MID, a1[15:8]);
      wr(FCSU_OFS_END_LOW, a1[7:0]);
   endtask

   // clears in user mode, then starts an automatic pass over 16 bytes
   task automatic auto_run(input logic alg, input logic [2:0] code);
      int n;
      exp = alg ? FCSU_SUM_INIT : FCSU_CRC_INIT;
      for (int a = 17'h1_2340; a <= 17'h1_234F; a++) exp = step(exp, a[7:0] ^ 8'h5A ^ {a[10:8], 5'h00}, alg);
      wr(FCSU_OFS_CONTROL, {2'b11, alg, 5'h00});
      wr(FCSU_OFS_CONTROL, {2'b00, alg, 1'b0, code, 1'b0});
      set_range(17'h1_2340, 17'h1_234F);
      wr(FCSU_OFS_CONTROL, {2'b00, alg, 1'b0, code, 1'b1});
      repeat (3) @(posedge sys_clk);
      #1;
      check("stall", {15'h0000, stall}, 16'h0001);
      check("irq mask", {15'h0000, mask}, 16'h0001);
      xfer(1'b0, FCSU_OFS_CONTROL, 8'h00);
      check("busy", {15'h0000, q[0]}, 16'h0001);
      n = 0;
      while (q[0] !== 1'b0 && n < 1000) begin
         xfer(1'b0, FCSU_OFS_CONTROL, 8'h00);
         n++;
      end
      if (n >= 1000) begin
         err_total++;
         stop_test();
      end
      // rc runs at five system cycles per period; each poll spans three cycles
      check("clock rate", {15'h0000, ((code == FCSU_CLK_SYS) ? (n < 16) : (n >= (16 << code)))}, 16'h0001);
      check("stall released", {15'h0000, stall}, 16'h0000);
      get_result();
      check("auto result", res, exp);
      wr(FCSU_OFS_DATA_IN, 8'h5A);
      get_result();
      check("din ignored in auto", res, exp);
   endtask

   // ==========================================================
   // main sequence
   initial begin
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         xfer(1'b0, ofs[i], 8'h00);
         check("reset value", {8'h00, q}, {8'h00, rst_v[i]});
      end
      xfer(1'b0, 6'h28, 8'h00);
      check("unmapped err", {15'h0000, e}, 16'h0001);
      wr(FCSU_OFS_START_LOW, 8'hA7);
      xfer(1'b0, FCSU_OFS_START_LOW, 8'h00);
      check("start low", {8'h00, q}, 16'h00A0);
      wr(FCSU_OFS_END_LOW, 8'h30);
      xfer(1'b0, FCSU_OFS_END_LOW, 8'h00);
      check("end low", {8'h00, q}, 16'h003F);
      wr(FCSU_OFS_RESULT_HIGH, 8'h12);
      get_result();
      check("result read only", res, 16'hFFFF);
      for (int alg = 0; alg < 2; alg++) begin
         wr(FCSU_OFS_CONTROL, {2'b11, alg[0], 5'h00});
         xfer(1'b0, FCSU_OFS_CONTROL, 8'h00);
         check("clear self-clears", {8'h00, q}, {8'h00, 2'b10, alg[0], 5'h00});
         get_result();
         exp = alg[0] ? FCSU_SUM_INIT : FCSU_CRC_INIT;
         check("clear value", res, exp);
         for (int b = 0; b < 6; b++) begin
            wr(FCSU_OFS_DATA_IN, 8'hF3 + 8'(b * 37));
            exp = step(exp, 8'hF3 + 8'(b * 37), alg[0]);
         end
         get_result();
         check("user result", res, exp);
      end
      // every clock code, alternating the algorithm
      for (int c = 0; c < 5; c++) begin
         auto_run(c[0], c[2:0]);
      end
      // abort a long pass in mid-run
      set_range(17'h0_0000, 17'h1_FFFF);
      wr(FCSU_OFS_CONTROL, {4'h2, FCSU_CLK_SYS, 1'b1});
      repeat (8) @(posedge sys_clk);
      wr(FCSU_OFS_CONTROL, {4'h2, FCSU_CLK_SYS, 1'b0});
      xfer(1'b0, FCSU_OFS_CONTROL, 8'h00);
      check("abort busy", {15'h0000, q[0]}, 16'h0000);
      check("abort stall", {15'h0000, stall}, 16'h0000);
      stop_test();
   end
endmodule // flash_crc_checksum_unit_bench
